// [pkg/ccs_regs.vh]
// constants of the clock source status block
// assumes: 32-bit avalon-mm words at byte offsets, 250 mhz clk
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CCS_OFS_CONTROL_ONE   4'h0
`define CCS_OFS_CURRENT       4'h4
`define CCS_OFS_READY_STATUS  4'h8

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define CCS_NEW_OSCILLATOR_SELECT_LSB          4
`define CCS_NEW_OSCILLATOR_SELECT_MSB          6
`define CCS_SOSC_XTAL_BIT     0
`define CCS_RDY_EXT           7
`define CCS_RDY_HF            6
`define CCS_RDY_MF            5
`define CCS_RDY_LF            4
`define CCS_RDY_SEC           3
`define CCS_RDY_ADRC          2
`define CCS_RDY_PLL           0

// ---------------------------------------------------------------
// oscillator choices and reset values
// ---------------------------------------------------------------
`define CCS_SRC_HF            3'h0
`define CCS_SRC_EXT_PLL       3'h1
`define CCS_SRC_SEC           3'h2
`define CCS_SRC_LF            3'h3
`define CCS_SRC_MF            3'h4
`define CCS_SRC_EXT           3'h5
`define CCS_PLL_FACTOR        3'h4
`define CCS_SEC_FREQ_KHZ      31
`define CCS_STABLE_CYCLES     16

`endif

// [rtl/ccs_ready_sync.v]
// ready synchroniser and stability filter for oscillator status lines
// assumes: inputs are asynchronous levels from the oscillator cells
`timescale 1ns/10ps
`default_nettype none
module ccs_ready_sync #(
  parameter WIDTH  = 8,
  parameter STABLE = 16
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] raw_in,
  output reg  [WIDTH-1:0] ready_q
);
  localparam CW = 8;
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [CW-1:0]    cnt_q [0:WIDTH-1];
  integer i;

  // ---------------------------------------------------------------
  // two flops, then a line must hold high for STABLE+1 cycles
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q  <= {WIDTH{1'b0}};
      sync_q  <= {WIDTH{1'b0}};
      ready_q <= {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1) begin
        cnt_q[i] <= {CW{1'b0}};
      end
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (!sync_q[i]) begin
          cnt_q[i]   <= {CW{1'b0}};
          ready_q[i] <= 1'b0;
        end else if (cnt_q[i] == STABLE[CW-1:0]) begin
          ready_q[i] <= 1'b1;
        end else begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end
endmodule // ccs_ready_sync
`default_nettype wire

// [rtl/ccs_top.v]
// clock source selection and oscillator ready status, avalon-mm slave
// assumes: ready and lock inputs asynchronous; strap steady at reset
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_regs.vh"
module ccs_top #(
  parameter STABLE = `CCS_STABLE_CYCLES
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [2:0]  reset_oscillator_select,
  input  wire        ext_osc_running,
  input  wire        hf_osc_running,
  input  wire        mf_osc_running,
  input  wire        lf_osc_running,
  input  wire        sec_osc_running,
  input  wire        adrc_osc_running,
  input  wire        pll_locked,
  output reg         external_oscillator_en,
  output reg         pll_en,
  output reg  [2:0]  pll_multiply,
  output reg         secondary_en,
  output reg         secondary_crystal_mode,
  output reg         internal_oscillator_en,
  output reg  [2:0]  clock_source_sel
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function src_ready;
    input [2:0] sel;
    input [7:0] rdy;
    begin
      case (sel)
        `CCS_SRC_HF:      src_ready = rdy[`CCS_RDY_HF];
        `CCS_SRC_EXT_PLL: src_ready = rdy[`CCS_RDY_PLL];
        `CCS_SRC_SEC:     src_ready = rdy[`CCS_RDY_SEC];
        `CCS_SRC_LF:      src_ready = rdy[`CCS_RDY_LF];
        `CCS_SRC_MF:      src_ready = rdy[`CCS_RDY_MF];
        `CCS_SRC_EXT:     src_ready = rdy[`CCS_RDY_EXT];
        default:          src_ready = 1'b0;
      endcase
    end
  endfunction

  function is_src;
    input [2:0] sel;
    input [2:0] want;
    begin
      is_src = (sel == want);
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [2:0] new_osc_q;
  reg        strap_done_q;
  reg        xtal_mode_q;
  wire [7:0] raw_rdy;
  wire [7:0] sync_rdy;
  reg  [7:0] status_d;
  reg  [2:0] cur_d;
  wire       req;
  wire       wr_go;
  wire       pll_want;
  wire       ext_want;
  wire       sec_want;
  wire       int_want;

  assign raw_rdy = {ext_osc_running, hf_osc_running, mf_osc_running,
                    lf_osc_running, sec_osc_running, adrc_osc_running,
                    1'b0, pll_locked};

  ccs_ready_sync #(
    .WIDTH  (8),
    .STABLE (STABLE)
  ) u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .raw_in  (raw_rdy),
    .ready_q (sync_rdy)
  );

  // ---------------------------------------------------------------
  // ready status, ext, sec and pll bits gated by enables
  // ---------------------------------------------------------------
  always @* begin
    status_d = 8'h00;
    status_d[`CCS_RDY_EXT]  = sync_rdy[`CCS_RDY_EXT] &
                              external_oscillator_en;
    status_d[`CCS_RDY_HF]   = sync_rdy[`CCS_RDY_HF];
    status_d[`CCS_RDY_MF]   = sync_rdy[`CCS_RDY_MF];
    status_d[`CCS_RDY_LF]   = sync_rdy[`CCS_RDY_LF];
    status_d[`CCS_RDY_SEC]  = sync_rdy[`CCS_RDY_SEC] & secondary_en;
    status_d[`CCS_RDY_ADRC] = sync_rdy[`CCS_RDY_ADRC];
    status_d[`CCS_RDY_PLL]  = sync_rdy[`CCS_RDY_PLL] & pll_en &
                              sync_rdy[`CCS_RDY_EXT];
  end

  // ---------------------------------------------------------------
  // enables follow current and requested source
  // ---------------------------------------------------------------
  assign pll_want = is_src(new_osc_q, `CCS_SRC_EXT_PLL) |
                    is_src(clock_source_sel, `CCS_SRC_EXT_PLL);
  assign ext_want = pll_want | is_src(new_osc_q, `CCS_SRC_EXT) |
                    is_src(clock_source_sel, `CCS_SRC_EXT);
  assign sec_want = is_src(new_osc_q, `CCS_SRC_SEC) |
                    is_src(clock_source_sel, `CCS_SRC_SEC);
  assign int_want = ~(ext_want & ~is_src(clock_source_sel, `CCS_SRC_HF) &
                      ~is_src(new_osc_q, `CCS_SRC_HF)) | 1'b0;

  // switch only once the requested source reports ready
  always @* begin
    cur_d = clock_source_sel;
    if (new_osc_q != clock_source_sel &&
        src_ready(new_osc_q, status_d)) begin
      cur_d = new_osc_q;
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave: one wait cycle per access
  // ---------------------------------------------------------------
  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & ~avs_waitrequest;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (avs_address)
          `CCS_OFS_CONTROL_ONE:
            avs_readdata <= {25'h000_0000, new_osc_q, 3'h0, xtal_mode_q};
          `CCS_OFS_CURRENT:
            avs_readdata <= {28'h000_0000,
                             new_osc_q != clock_source_sel,
                             clock_source_sel};
          `CCS_OFS_READY_STATUS:
            avs_readdata <= {24'h00_0000, status_d};
          default:
            avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // control register, strap capture after reset release
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done_q <= 1'b0;
      new_osc_q    <= `CCS_SRC_HF;
      xtal_mode_q  <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      new_osc_q    <= reset_oscillator_select;
    end else if (wr_go && avs_address == `CCS_OFS_CONTROL_ONE &&
                 avs_byteenable[0]) begin
      new_osc_q   <= avs_writedata[`CCS_NEW_OSCILLATOR_SELECT_MSB:`CCS_NEW_OSCILLATOR_SELECT_LSB];
      xtal_mode_q <= avs_writedata[`CCS_SOSC_XTAL_BIT];
    end
    // writes to the status and current offsets are dropped
  end

  // ---------------------------------------------------------------
  // oscillator controls
  // ---------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_source_sel       <= `CCS_SRC_HF;
      external_oscillator_en <= 1'b0;
      pll_en                 <= 1'b0;
      pll_multiply           <= `CCS_PLL_FACTOR;
      secondary_en           <= 1'b0;
      secondary_crystal_mode <= 1'b1;
      internal_oscillator_en <= 1'b1;
    end else begin
      if (strap_done_q) begin
        clock_source_sel <= cur_d;
      end
      external_oscillator_en <= strap_done_q & ext_want;
      pll_en                 <= strap_done_q & pll_want;
      pll_multiply           <= `CCS_PLL_FACTOR;
      secondary_en           <= strap_done_q & sec_want;
      secondary_crystal_mode <= xtal_mode_q;
      internal_oscillator_en <= int_want;
    end
  end

endmodule // ccs_top
`default_nettype wire

// [tb/ccs_osc_model.sv]
// oscillator cells: run a few cycles after enable
// assumes: clk and arst_n shared with ccs_top
`timescale 1ns/10ps
`default_nettype none
module ccs_osc_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ext_en,
  input  wire logic pll_en,
  input  wire logic sec_en,
  input  wire logic int_en,
  output var  logic ext_run,
  output var  logic pll_lock,
  output var  logic sec_run,
  output var  logic int_run
);
  logic [3:0] ext_q, pll_q, sec_q, int_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {ext_q, pll_q, sec_q, int_q} <= '0;
    end else begin
      ext_q <= {ext_q[2:0], ext_en};
      pll_q <= {pll_q[2:0], pll_en && ext_run};
      sec_q <= {sec_q[2:0], sec_en};
      int_q <= {int_q[2:0], int_en};
    end
  end
  assign ext_run = ext_q[3];
  assign pll_lock = pll_q[3];
  assign sec_run = sec_q[3];
  assign int_run = int_q[3];
endmodule // ccs_osc_model
`default_nettype wire

// [tb/ccs_top_sva.sv]
// assertions on the ports of ccs_top
// assumes: bound into ccs_top from the bench top file
`timescale 1ns/10ps
`default_nettype none
module ccs_top_sva #(
  parameter STABLE = 16
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  reset_oscillator_select,
  input wire logic        external_oscillator_en,
  input wire logic        pll_en,
  input wire logic [2:0]  pll_multiply,
  input wire logic        secondary_en,
  input wire logic        secondary_crystal_mode,
  input wire logic [2:0]  clock_source_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wr = avs_write && !avs_waitrequest;
  wire rd = avs_read && !avs_waitrequest;
  wire cw = wr && avs_address == 4'h0 && avs_byteenable[0];
  wire st = rd && avs_address == 4'h8;
  wire xp = external_oscillator_en && pll_en;
  property p_mul;
    pll_en |-> pll_multiply == 3'h4 && external_oscillator_en;
  endproperty
  a_mul: assert property (p_mul) else $error("pll factor wrong");
  property p_strap;
    $rose(arst_n) && reset_oscillator_select == 3'h1 |-> ##[1:3] xp;
  endproperty
  a_strap: assert property (p_strap) else $error("strap no pll");
  property p_new_oscillator_select; cw && avs_writedata[6:4] == 3'h1 |-> ##[1:3] xp;
  endproperty
  a_new_oscillator_select: assert property (p_new_oscillator_select) else $error("write no pll");
  property p_sec; clock_source_sel == 3'h2 |-> secondary_en; endproperty
  a_sec: assert property (p_sec) else $error("sec off when used");
  property p_xtal;
    cw |-> ##2 secondary_crystal_mode == $past(avs_writedata[0], 2);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal mode");
  property p_stat;
    st |-> (!avs_readdata[0] || $past(pll_en)) && (!avs_readdata[3] ||
      $past(secondary_en)) && (!avs_readdata[7] ||
      $past(external_oscillator_en));
  endproperty
  a_stat: assert property (p_stat) else $error("ready not enabled");
  property p_ro;
    st |-> avs_readdata[31:8] == 24'h00_0000 && !avs_readdata[1];
  endproperty
  a_ro: assert property (p_ro) else $error("status spare bits");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  c_sw: cover property (clock_source_sel == 3'h2);
  c_pll: cover property (st && avs_readdata[0]);
  c_ro: cover property (wr && avs_address == 4'h8);
endmodule // ccs_top_sva
`default_nettype wire

// [tb/ccs_top_test.sv]
// self-checking bench for ccs_top over avalon-mm
// assumes: ccs_regs.vh on the include path
`timescale 1ns/10ps
`default_nettype none
module ccs_top_test;
  logic        clk = 0, arst_n = 0, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000, r;
  logic [2:0]  strap = 3'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, ext_en, pll_en, sec_en, xtal, int_en;
  wire         ext_run, pll_lock, sec_run, int_run;
  wire  [2:0]  mul, src;
  int          error_cnt = 0, samples_checked = 0;
  initial forever #2 clk = ~clk;
  ccs_top #(.STABLE(2)) u_ccs_top (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_oscillator_select(strap),
    .ext_osc_running(ext_run), .hf_osc_running(int_run),
    .mf_osc_running(int_run), .lf_osc_running(int_run),
    .sec_osc_running(sec_run), .adrc_osc_running(int_run),
    .pll_locked(pll_lock), .external_oscillator_en(ext_en),
    .pll_en(pll_en), .pll_multiply(mul), .secondary_en(sec_en),
    .secondary_crystal_mode(xtal), .internal_oscillator_en(int_en),
    .clock_source_sel(src));
  ccs_osc_model u_ccs_osc_model (.clk(clk), .arst_n(arst_n),
    .ext_en(ext_en), .pll_en(pll_en), .sec_en(sec_en), .int_en(int_en),
    .ext_run(ext_run), .pll_lock(pll_lock), .sec_run(sec_run),
    .int_run(int_run));
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [3:0] a, logic [31:0] d,
                     logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    r = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] e, string n);
    acc(0, a, 32'h0000_0000, 4'hf);
    chk(n, r, e);
  endtask
  task automatic poll(logic [7:0] m);
    int k;
    for (k = 0; k < 60; k++) begin
      acc(0, 4'h8, 32'h0000_0000, 4'hf);
      if ((r[7:0] & m) == m) break;
    end
    if (k == 60) error_cnt++;
  endtask
  task automatic rst(logic [2:0] s);
    arst_n <= 0;
    strap <= s;
    repeat (6) @(posedge clk);
    arst_n <= 1;
    repeat (2) @(posedge clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    rst(3'h0);
    rd(4'h0, 32'h0000_0001, "ctrl");
    chk("enables", {29'h0, int_en, ext_en, pll_en}, 32'h0000_0004);
    rd(4'h4, 32'h0000_0000, "current");
    poll(8'h74);
    rd(4'h8, 32'h0000_0074, "status");
    acc(1, 4'h8, 32'h0000_00ff, 4'hf);
    rd(4'h8, 32'h0000_0074, "status");
    rd(4'h0, 32'h0000_0001, "ctrl");
    rd(4'hc, 32'h0000_0000, "unmapped");
    $display("test status done");
    acc(1, 4'h0, 32'h0000_0011, 4'hf);
    chk("mul", {29'h0, mul}, 32'h0000_0004);
    poll(8'h81);
    rd(4'h8, 32'h0000_00f5, "status");
    rd(4'h4, 32'h0000_0001, "current");
    $display("test pll done");
    acc(1, 4'h0, 32'h0000_0020, 4'hf);
    @(posedge clk);
    chk("xtal", {31'h0, xtal}, 32'h0000_0000);
    poll(8'h08);
    rd(4'h4, 32'h0000_0002, "current");
    chk("source", {29'h0, src}, 32'h0000_0002);
    chk("sec_en", {31'h0, sec_en}, 32'h0000_0001);
    acc(1, 4'h0, 32'h0000_0021, 4'hf);
    @(posedge clk);
    chk("xtal", {31'h0, xtal}, 32'h0000_0001);
    acc(1, 4'h0, 32'h0000_0000, 4'he);
    rd(4'h0, 32'h0000_0021, "ctrl");
    acc(1, 4'h0, 32'h0000_0051, 4'hf);
    poll(8'h80);
    rd(4'h4, 32'h0000_0005, "current");
    chk("source", {29'h0, src}, 32'h0000_0005);
    chk("sec_en", {31'h0, sec_en}, 32'h0000_0000);
    $display("test secondary done");
    rst(3'h1);
    rd(4'h0, 32'h0000_0011, "ctrl");
    chk("enables", {30'h0, ext_en, pll_en}, 32'h0000_0003);
    poll(8'h81);
    rd(4'h4, 32'h0000_0001, "current");
    $display("test strap done");
    report_and_stop;
  end
endmodule // ccs_top_test
bind ccs_top ccs_top_sva #(.STABLE(STABLE)) u_ccs_top_sva (
  .clk                     (clk),
  .arst_n                  (arst_n),
  .avs_address             (avs_address),
  .avs_read                (avs_read),
  .avs_write               (avs_write),
  .avs_writedata           (avs_writedata),
  .avs_byteenable          (avs_byteenable),
  .avs_readdata            (avs_readdata),
  .avs_waitrequest         (avs_waitrequest),
  .reset_oscillator_select (reset_oscillator_select),
  .external_oscillator_en  (external_oscillator_en),
  .pll_en                  (pll_en),
  .pll_multiply            (pll_multiply),
  .secondary_en            (secondary_en),
  .secondary_crystal_mode  (secondary_crystal_mode),
  .clock_source_sel        (clock_source_sel)
);
`default_nettype wire
